// File: common/cell_limit_pkg.sv
// Constants, register map and types for the cell voltage limit checker.
// Assumes a byte-wide register port driven by the serial host interface logic.
package cell_limit_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] HIGH_CELL_LIMIT_LOW_OFS      = 8'h00;
  localparam logic [7:0] CHARGER_WINDOW_AND_HIGH_OFS  = 8'h01;
  localparam logic [7:0] HIGH_CELL_RECOVERY_LOW_OFS   = 8'h02;
  localparam logic [7:0] HIGH_CELL_RECOVERY_HIGH_OFS  = 8'h03;
  localparam logic [7:0] LOW_CELL_LIMIT_LOW_OFS       = 8'h04;
  localparam logic [7:0] LOAD_WINDOW_AND_LOW_HIGH_OFS = 8'h05;
  localparam logic [7:0] LOW_CELL_RECOVERY_LOW_OFS    = 8'h06;
  localparam logic [7:0] LOW_CELL_RECOVERY_HIGH_OFS   = 8'h07;
  localparam logic [7:0] FAULT_STATUS_OFS             = 8'h80;
  localparam logic [7:0] PRESENCE_STATUS_OFS          = 8'h82;
  localparam int         NUM_CFG_REGS                 = 8;

  // ****************************************************************
  // Field positions and masks
  // ****************************************************************
  localparam int         HIGH_CELL_FAULT_BIT  = 0;
  localparam int         LOW_CELL_FAULT_BIT   = 2;
  localparam int         LOAD_PRESENT_BIT     = 0;
  localparam int         CHARGER_PRESENT_BIT  = 1;
  localparam int         WINDOW_FIELD_LSB     = 4;
  localparam logic [7:0] RESERVED_NIBBLE_MASK = 8'h0F;
  localparam logic [7:0] FULL_BYTE_MASK       = 8'hFF;
  localparam logic [11:0] CODE_FULL_SCALE     = 12'hFFF;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [7:0] HIGH_CELL_LIMIT_LOW_RST      = 8'h2A;
  localparam logic [7:0] CHARGER_WINDOW_AND_HIGH_RST  = 8'h1E;
  localparam logic [7:0] HIGH_CELL_RECOVERY_LOW_RST   = 8'hD4;
  localparam logic [7:0] HIGH_CELL_RECOVERY_HIGH_RST  = 8'h0D;
  localparam logic [7:0] LOW_CELL_LIMIT_LOW_RST       = 8'hFF;
  localparam logic [7:0] LOAD_WINDOW_AND_LOW_HIGH_RST = 8'h18;
  localparam logic [7:0] LOW_CELL_RECOVERY_LOW_RST    = 8'hFF;
  localparam logic [7:0] LOW_CELL_RECOVERY_HIGH_RST   = 8'h09;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int WINDOW_STEP_MS      = 1;
  localparam int CLK_PERIOD_NS       = 40;
  localparam int NS_PER_MS           = 1000000;
  localparam int WINDOW_STEP_CYCLES  = (WINDOW_STEP_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic {
    DET_IDLE = 1'b0,
    DET_RUN  = 1'b1
  } det_state_t;
endpackage

// File: hw/cell_voltage_limit_checker.sv
// Cell voltage limit checking, fault flags, switch drives and the two detect windows.
// Assumes one measurement per enabled cell with meas_last on the final cell of a scan,
// timer durations in core_clk cycles, and comparator levels on the two monitor pins.
// Overview of operation
// RL1: Charger window lasts field value in milliseconds.
// RL2: Charger present if pin high at end.
// RL3: Load current on charger node during window.
// RL4: High recovery level at 0x02, 0x03 nibble.
// RL5: Software writes zero to reserved nibbles.
// RL6: Software keeps high recovery below high limit.
// RL7: High fault clears after timed recovery.
// RL8: Charge-off setting and host control gate switch.
// RL9: High recovery level releases high lockout.
// RL10: Low limit from 0x04, 0x05 nibble.
// RL11: Timed low cell trips discharge and flag.
// RL12: Discharge-off setting and host control gate switch.
// RL13: Load window field bits 7:4, millisecond steps.
// RL14: Load node loaded; present if pin low.
// RL15: Low recovery level at 0x06, 0x07 nibble.
// RL16: Software keeps low recovery above low limit.
// RL17: Low fault clears after timed recovery.
// RL18: Low recovery level releases low lockout.
// RL19: Codes are unsigned twelve bit, full scale.
// RL20: Timed high cell trips charge and flag.
// RL21: High limit from 0x00, 0x01 nibble.
// RL22: Full thresholds; presence updates at window end.
`timescale 1ns/10ps
module cell_voltage_limit_checker #(
  parameter int MS_CYCLES = cell_limit_pkg::WINDOW_STEP_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  output logic      [7:0]  reg_rdata,
  input  wire logic        meas_valid,
  input  wire logic        meas_last,
  input  wire logic [11:0] meas_code,
  input  wire logic [15:0] high_cell_timer_cycles,
  input  wire logic [15:0] low_cell_timer_cycles,
  input  wire logic        charge_off_on_high_cell,
  input  wire logic        discharge_off_on_low_cell,
  input  wire logic        host_switch_control,
  input  wire logic        host_charge_on,
  input  wire logic        host_discharge_on,
  input  wire logic        other_charge_fault,
  input  wire logic        other_discharge_fault,
  input  wire logic        high_cell_lockout,
  input  wire logic        low_cell_lockout,
  input  wire logic        charger_detect_start,
  input  wire logic        load_detect_start,
  input  wire logic        charger_monitor_pin,
  input  wire logic        load_monitor_pin,
  output logic             charge_switch_drive,
  output logic             discharge_switch_drive,
  output logic             high_cell_fault_flag,
  output logic             low_cell_fault_flag,
  output logic             high_cell_lockout_release,
  output logic             low_cell_lockout_release,
  output logic             monitor_load_current_charger,
  output logic             monitor_load_current_load,
  output logic             charger_present_flag,
  output logic             load_present_flag
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    cell_limit_pkg::det_state_t st;
    logic [14:0]                sub;
    logic [3:0]                 ms;
  } window_t;

  typedef struct packed {
    logic [7:0][7:0] cfg;
    logic [7:0]      rdata;
    logic [1:0]      chg_sync;
    logic [1:0]      ld_sync;
    logic            acc_over;
    logic            acc_hrec;
    logic            acc_under;
    logic            acc_lrec;
    logic            s_over;
    logic            s_hrec;
    logic            s_under;
    logic            s_lrec;
    logic [15:0]     hc_cnt;
    logic [15:0]     lc_cnt;
    logic            hcf;
    logic            lcf;
    logic            chg_drv;
    logic            dis_drv;
    window_t         cw;
    window_t         lw;
    logic            ch_present;
    logic            ld_present;
  } state_t;

  state_t r;
  state_t next_r;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] write_mask(input logic [7:0] addr);
    if (addr == cell_limit_pkg::HIGH_CELL_RECOVERY_HIGH_OFS ||
        addr == cell_limit_pkg::LOW_CELL_RECOVERY_HIGH_OFS) begin
      write_mask = cell_limit_pkg::RESERVED_NIBBLE_MASK;  // RL4 RL15
    end else begin
      write_mask = cell_limit_pkg::FULL_BYTE_MASK;
    end
  endfunction

  // Twelve-bit code from a low byte and the low nibble of the next byte
  function automatic logic [11:0] code12(input logic [7:0] lo, input logic [7:0] hi);
    code12 = {hi[3:0], lo};  // RL22
  endfunction

  function automatic logic window_done(input window_t w, input logic start, input logic [3:0] width);
    window_done = (w.st == cell_limit_pkg::DET_IDLE && start && width == 4'h0) ||
                  (w.st == cell_limit_pkg::DET_RUN && w.sub == 15'(MS_CYCLES - 1) &&
                   ({1'b0, w.ms} + 5'h01 >= {1'b0, width}));
  endfunction

  // Millisecond window: sub counts clock cycles, ms counts whole milliseconds
  function automatic window_t window_step(input window_t w, input logic start, input logic [3:0] width);
    window_t n;
    n = w;
    if (window_done(w, start, width)) begin
      n = '0;
    end else if (w.st == cell_limit_pkg::DET_IDLE) begin
      if (start) begin
        n.st = cell_limit_pkg::DET_RUN;  // RL1 RL13
      end
    end else if (w.sub == 15'(MS_CYCLES - 1)) begin
      n.sub = 15'h0000;
      n.ms  = w.ms + 4'h1;
    end else begin
      n.sub = w.sub + 15'h0001;
    end
    return n;
  endfunction

  // Counts while the condition holds, restarts when it breaks, saturates
  function automatic logic [15:0] timer_step(input logic [15:0] cnt, input logic cond);
    if (!cond) begin
      timer_step = 16'h0000;
    end else if (cnt == 16'hFFFF) begin
      timer_step = cnt;
    end else begin
      timer_step = cnt + 16'h0001;
    end
  endfunction

  // ****************************************************************
  // Decoded values
  // ****************************************************************
  logic [11:0] high_limit;
  logic [11:0] high_rec;
  logic [11:0] low_limit;
  logic [11:0] low_rec;
  logic [3:0]  chg_width;
  logic [3:0]  ld_width;
  logic        ch_done;
  logic        ld_done;
  logic        m_over;
  logic        m_hrec;
  logic        m_under;
  logic        m_lrec;

  always_comb begin
    high_limit = code12(r.cfg[0], r.cfg[1]);  // RL21
    high_rec   = code12(r.cfg[2], r.cfg[3]);  // RL4
    low_limit  = code12(r.cfg[4], r.cfg[5]);  // RL10
    low_rec    = code12(r.cfg[6], r.cfg[7]);  // RL15
    chg_width  = r.cfg[1][cell_limit_pkg::WINDOW_FIELD_LSB +: 4];
    ld_width   = r.cfg[5][cell_limit_pkg::WINDOW_FIELD_LSB +: 4];  // RL13
    ch_done    = window_done(r.cw, charger_detect_start, chg_width);
    ld_done    = window_done(r.lw, load_detect_start, ld_width);
    // Unsigned compares over the full code range
    m_over     = meas_code > high_limit;  // RL19 RL20
    m_hrec     = meas_code < high_rec;
    m_under    = meas_code < low_limit;   // RL11
    m_lrec     = meas_code > low_rec;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_r = r;

    if (reg_wr && reg_addr < 8'(cell_limit_pkg::NUM_CFG_REGS)) begin
      next_r.cfg[reg_addr[2:0]] = reg_wdata & write_mask(reg_addr);
    end

    case (reg_addr)
      cell_limit_pkg::FAULT_STATUS_OFS: begin
        next_r.rdata = 8'h00;
        next_r.rdata[cell_limit_pkg::HIGH_CELL_FAULT_BIT] = r.hcf;
        next_r.rdata[cell_limit_pkg::LOW_CELL_FAULT_BIT]  = r.lcf;
      end
      cell_limit_pkg::PRESENCE_STATUS_OFS: begin
        next_r.rdata = 8'h00;
        next_r.rdata[cell_limit_pkg::CHARGER_PRESENT_BIT] = r.ch_present;
        next_r.rdata[cell_limit_pkg::LOAD_PRESENT_BIT]    = r.ld_present;
      end
      default: begin
        next_r.rdata = (reg_addr < 8'(cell_limit_pkg::NUM_CFG_REGS)) ? r.cfg[reg_addr[2:0]] : 8'h00;
      end
    endcase

    next_r.chg_sync = {r.chg_sync[0], charger_monitor_pin};
    next_r.ld_sync  = {r.ld_sync[0], load_monitor_pin};

    // Scan summary: any cell past a limit, every cell past a recovery level
    if (meas_valid) begin
      next_r.acc_over  = r.acc_over | m_over;
      next_r.acc_hrec  = r.acc_hrec & m_hrec;
      next_r.acc_under = r.acc_under | m_under;
      next_r.acc_lrec  = r.acc_lrec & m_lrec;
      if (meas_last) begin
        next_r.s_over    = r.acc_over | m_over;
        next_r.s_hrec    = r.acc_hrec & m_hrec;    // RL9
        next_r.s_under   = r.acc_under | m_under;
        next_r.s_lrec    = r.acc_lrec & m_lrec;    // RL18
        next_r.acc_over  = 1'b0;
        next_r.acc_hrec  = 1'b1;
        next_r.acc_under = 1'b0;
        next_r.acc_lrec  = 1'b1;
      end
    end

    // One timer per fault, measuring trip time or recovery time
    next_r.hc_cnt = timer_step(r.hc_cnt, r.hcf ? r.s_hrec : r.s_over);
    next_r.lc_cnt = timer_step(r.lc_cnt, r.lcf ? r.s_lrec : r.s_under);
    if (r.hc_cnt >= high_cell_timer_cycles && (r.hcf ? r.s_hrec : r.s_over)) begin
      next_r.hcf    = !r.hcf;  // RL7 RL20
      next_r.hc_cnt = 16'h0000;
    end
    if (r.lc_cnt >= low_cell_timer_cycles && (r.lcf ? r.s_lrec : r.s_under)) begin
      next_r.lcf    = !r.lcf;  // RL11 RL17
      next_r.lc_cnt = 16'h0000;
    end

    // Lockouts always win, host control bypasses the automatic fault action
    if (host_switch_control) begin
      next_r.chg_drv = host_charge_on & !high_cell_lockout;  // RL8
      next_r.dis_drv = host_discharge_on & !low_cell_lockout;  // RL12
    end else begin
      next_r.chg_drv = !(r.hcf & charge_off_on_high_cell) & !other_charge_fault & !high_cell_lockout;  // RL7 RL8
      next_r.dis_drv = !(r.lcf & discharge_off_on_low_cell) & !other_discharge_fault & !low_cell_lockout;  // RL12 RL17
    end

    next_r.cw = window_step(r.cw, charger_detect_start, chg_width);
    next_r.lw = window_step(r.lw, load_detect_start, ld_width);
    if (ch_done) begin
      next_r.ch_present = r.chg_sync[1];  // RL2 RL22
    end
    if (ld_done) begin
      next_r.ld_present = !r.ld_sync[1];  // RL14 RL22
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      r          <= '0;
      r.cfg[0]   <= cell_limit_pkg::HIGH_CELL_LIMIT_LOW_RST;
      r.cfg[1]   <= cell_limit_pkg::CHARGER_WINDOW_AND_HIGH_RST;
      r.cfg[2]   <= cell_limit_pkg::HIGH_CELL_RECOVERY_LOW_RST;
      r.cfg[3]   <= cell_limit_pkg::HIGH_CELL_RECOVERY_HIGH_RST;
      r.cfg[4]   <= cell_limit_pkg::LOW_CELL_LIMIT_LOW_RST;
      r.cfg[5]   <= cell_limit_pkg::LOAD_WINDOW_AND_LOW_HIGH_RST;
      r.cfg[6]   <= cell_limit_pkg::LOW_CELL_RECOVERY_LOW_RST;
      r.cfg[7]   <= cell_limit_pkg::LOW_CELL_RECOVERY_HIGH_RST;
      r.acc_hrec <= 1'b1;
      r.acc_lrec <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata                    = r.rdata;
  assign charge_switch_drive          = r.chg_drv;
  assign discharge_switch_drive       = r.dis_drv;
  assign high_cell_fault_flag         = r.hcf;
  assign low_cell_fault_flag          = r.lcf;
  assign high_cell_lockout_release    = r.s_hrec;  // RL9
  assign low_cell_lockout_release     = r.s_lrec;  // RL18
  assign monitor_load_current_charger = r.cw.st == cell_limit_pkg::DET_RUN;  // RL3
  assign monitor_load_current_load    = r.lw.st == cell_limit_pkg::DET_RUN;  // RL14
  assign charger_present_flag         = r.ch_present;
  assign load_present_flag            = r.ld_present;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence chg_window_start;
    r.cw.st == cell_limit_pkg::DET_IDLE && charger_detect_start && chg_width != 4'h0;
  endsequence

  sequence chg_window_end;
    ch_done ##1 !monitor_load_current_charger;
  endsequence

  chk_charger_load_on: assert property (chg_window_start |=> monitor_load_current_charger) // RL3
    else $error("charger load current not applied at window start");
  chk_charger_load_off: assert property (r.cw.st == cell_limit_pkg::DET_RUN && ch_done |-> chg_window_end) // RL1
    else $error("charger load current not removed at window end");
  chk_charger_sample: assert property (ch_done |=> charger_present_flag == $past(r.chg_sync[1])) // RL2
    else $error("charger presence not sampled at window end");
  chk_load_sample: assert property (ld_done |=> load_present_flag == !$past(r.ld_sync[1])) // RL14
    else $error("load presence not sampled at window end");
  chk_presence_hold: assert property (!ch_done && !ld_done // RL22
                                     |=> $stable(charger_present_flag) && $stable(load_present_flag))
    else $error("presence flag moved outside window end");
  chk_high_fault_set: assert property ($rose(high_cell_fault_flag) |-> $past(r.s_over) && // RL20
                                      $past(r.hc_cnt) >= $past(high_cell_timer_cycles))
    else $error("high cell fault set without timed trip");
  chk_high_fault_clear: assert property ($fell(high_cell_fault_flag) |-> $past(r.s_hrec)) // RL7
    else $error("high cell fault cleared without recovery");
  chk_low_fault_clear: assert property ($fell(low_cell_fault_flag) |-> $past(r.s_lrec)) // RL17
    else $error("low cell fault cleared without recovery");
  chk_charge_cut: assert property (high_cell_fault_flag && charge_off_on_high_cell && !host_switch_control // RL8
                                  |=> !charge_switch_drive)
    else $error("charge switch on during high cell fault");
  chk_discharge_cut: assert property (low_cell_fault_flag && discharge_off_on_low_cell && !host_switch_control // RL12
                                     |=> !discharge_switch_drive)
    else $error("discharge switch on during low cell fault");
  chk_reserved_read: assert property (reg_addr == cell_limit_pkg::HIGH_CELL_RECOVERY_HIGH_OFS // RL4
                                     |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved nibble reads nonzero");
endmodule

// File: dv/pack_terminal_model.sv
// Behavioural charger and load as seen on the two monitor pins.
// Assumes a pin level of 1 means the node sits above its comparator threshold.
`timescale 1ns/10ps
module pack_terminal_model (
  input  wire logic charger_attached,
  input  wire logic load_attached,
  input  wire logic monitor_load_current_charger,
  input  wire logic monitor_load_current_load,
  output logic      charger_monitor_pin,
  output logic      load_monitor_pin
);
  // ****************************************************************
  // Node levels under the monitor sink current
  // ****************************************************************
  // A charger holds the node up against the sink; an open node collapses under it
  assign charger_monitor_pin = charger_attached | ~monitor_load_current_charger;
  // A load drags the node low only while the sink is applied
  assign load_monitor_pin = ~(load_attached & monitor_load_current_load);
endmodule

// File: dv/testbench.sv
// Self-checking bench for the cell voltage limit checker.
// Assumes the detect step shortened to 3 cycles and fault timers of 4 cycles.
`timescale 1ns/10ps
module testbench;
  // ****************************************************************
  // Design, partner and drivers
  // ****************************************************************
  localparam int MS  = 3;
  localparam int TMR = 4;
  logic        core_clk, rst_b, reg_wr, meas_valid, meas_last;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [11:0] meas_code;
  logic [15:0] high_cell_timer_cycles, low_cell_timer_cycles;
  logic        charge_off_on_high_cell, discharge_off_on_low_cell, host_switch_control;
  logic        host_charge_on, host_discharge_on, other_charge_fault, other_discharge_fault;
  logic        high_cell_lockout, low_cell_lockout, charger_detect_start, load_detect_start;
  logic        charger_monitor_pin, load_monitor_pin, charger_attached, load_attached;
  logic        charge_switch_drive, discharge_switch_drive, high_cell_fault_flag, low_cell_fault_flag;
  logic        high_cell_lockout_release, low_cell_lockout_release, charger_present_flag, load_present_flag;
  logic        monitor_load_current_charger, monitor_load_current_load;
  logic [1:0]  flags;
  int          errors, check_count;
  assign flags = {low_cell_fault_flag, high_cell_fault_flag};

  cell_voltage_limit_checker #(.MS_CYCLES(MS)) DUT (
    .core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .meas_valid, .meas_last,
    .meas_code, .high_cell_timer_cycles, .low_cell_timer_cycles, .charge_off_on_high_cell,
    .discharge_off_on_low_cell, .host_switch_control, .host_charge_on, .host_discharge_on,
    .other_charge_fault, .other_discharge_fault, .high_cell_lockout, .low_cell_lockout,
    .charger_detect_start, .load_detect_start, .charger_monitor_pin, .load_monitor_pin,
    .charge_switch_drive, .discharge_switch_drive, .high_cell_fault_flag, .low_cell_fault_flag,
    .high_cell_lockout_release, .low_cell_lockout_release, .monitor_load_current_charger,
    .monitor_load_current_load, .charger_present_flag, .load_present_flag
  );
  pack_terminal_model partner (
    .charger_attached, .load_attached, .monitor_load_current_charger, .monitor_load_current_load,
    .charger_monitor_pin, .load_monitor_pin
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge core_clk);
    reg_wr = 1'h0;
  endtask

  // Read data lags the address by one edge; two edges leave margin after a write
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    reg_addr = a;
    repeat (2) @(negedge core_clk);
    chk(reg_rdata, exp);
  endtask

  task automatic meas(input logic [11:0] code);
    @(negedge core_clk);
    meas_valid = 1'h1;
    meas_last = 1'h1;
    meas_code = code;
    @(negedge core_clk);
    meas_valid = 1'h0;
    meas_last = 1'h0;
  endtask

  task automatic wait_flag(input int sel, input logic v);
    for (int i = 0; i < 12; i++) begin
      if (flags[sel] === v) break;
      @(negedge core_clk);
    end
    chk(flags[sel], v);
    if (flags[sel] !== v) conclude();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic reset_values();
    logic [7:0] rv [8] = '{8'h2A, 8'h1E, 8'hD4, 8'h0D, 8'hFF, 8'h18, 8'hFF, 8'h09};
    for (int i = 0; i < 8; i++) rd(8'(i), rv[i]);
    wr(8'h03, 8'hFF);
    rd(8'h03, 8'h0F);
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h0F);
    wr(8'h40, 8'h55);
    rd(8'h40, 8'h00);
    rd(8'h00, 8'h2A);
    rd(8'h80, 8'h00);
  endtask

  task automatic low_fault();
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h14);
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h05);
    chk(discharge_switch_drive, 1'h1);
    meas(12'h3FF);
    repeat (TMR - 1) @(negedge core_clk);
    chk(low_cell_fault_flag, 1'h0);
    wait_flag(1, 1'h1);
    rd(8'h80, 8'h04);
    chk(discharge_switch_drive, 1'h0);
    host_switch_control = 1'h1;
    host_discharge_on = 1'h1;
    repeat (2) @(negedge core_clk);
    chk(discharge_switch_drive, 1'h1);
    low_cell_lockout = 1'h1;
    repeat (2) @(negedge core_clk);
    chk(discharge_switch_drive, 1'h0);
    low_cell_lockout = 1'h0;
    host_switch_control = 1'h0;
    meas(12'h500);
    @(negedge core_clk);
    chk(low_cell_lockout_release, 1'h0);
    repeat (TMR + 4) @(negedge core_clk);
    chk(low_cell_fault_flag, 1'h1);
    meas(12'h501);
    @(negedge core_clk);
    chk(low_cell_lockout_release, 1'h1);
    wait_flag(1, 1'h0);
    repeat (2) @(negedge core_clk);
    chk(discharge_switch_drive, 1'h1);
  endtask

  task automatic high_fault();
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h18);
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h07);
    meas(12'h800);
    repeat (TMR + 4) @(negedge core_clk);
    chk(high_cell_fault_flag, 1'h0);
    meas(12'h801);
    repeat (TMR - 1) @(negedge core_clk);
    chk(high_cell_fault_flag, 1'h0);
    wait_flag(0, 1'h1);
    rd(8'h80, 8'h01);
    chk(charge_switch_drive, 1'h1);
    charge_off_on_high_cell = 1'h1;
    repeat (2) @(negedge core_clk);
    chk(charge_switch_drive, 1'h0);
    host_switch_control = 1'h1;
    host_charge_on = 1'h1;
    repeat (2) @(negedge core_clk);
    chk(charge_switch_drive, 1'h1);
    high_cell_lockout = 1'h1;
    repeat (2) @(negedge core_clk);
    chk(charge_switch_drive, 1'h0);
    high_cell_lockout = 1'h0;
    host_switch_control = 1'h0;
    meas(12'h700);
    @(negedge core_clk);
    chk(high_cell_lockout_release, 1'h0);
    other_charge_fault = 1'h1;
    meas(12'h6FF);
    @(negedge core_clk);
    chk(high_cell_lockout_release, 1'h1);
    chk(high_cell_fault_flag, 1'h1);
    wait_flag(0, 1'h0);
    repeat (2) @(negedge core_clk);
    chk(charge_switch_drive, 1'h0);
    other_charge_fault = 1'h0;
    repeat (2) @(negedge core_clk);
    chk(charge_switch_drive, 1'h1);
  endtask

  // A second start inside the window must not stretch it
  task automatic detect(input bit ld, input logic [3:0] w, input logic att);
    int   n;
    logic exp;
    n = 0;
    exp = (w == 4'h0) ? ~ld : att;
    charger_attached = att;
    load_attached = att;
    wr(ld ? 8'h05 : 8'h01, {w, ld ? 4'h4 : 4'h8});
    for (int i = 0; i < w * MS + 4; i++) begin
      @(negedge core_clk);
      n += ld ? monitor_load_current_load : monitor_load_current_charger;
      charger_detect_start = !ld && (i == 0 || i == 2);
      load_detect_start = ld && (i == 0 || i == 2);
    end
    chk(n[11:0], 12'(w * MS));
    chk(ld ? load_present_flag : charger_present_flag, exp);
  endtask

  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    errors = 0;
    check_count = 0;
    {rst_b, reg_wr, meas_valid, meas_last, host_switch_control, host_charge_on} = 6'h00;
    {host_discharge_on, other_charge_fault, other_discharge_fault, high_cell_lockout} = 4'h0;
    {low_cell_lockout, charger_detect_start, load_detect_start} = 3'h0;
    {charger_attached, load_attached, charge_off_on_high_cell} = 3'h0;
    discharge_off_on_low_cell = 1'h1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    meas_code = 12'h000;
    high_cell_timer_cycles = 16'(TMR);
    low_cell_timer_cycles = 16'(TMR);
    repeat (10) @(negedge core_clk);
    rst_b = 1'h1;
    reset_values();
    low_fault();
    high_fault();
    detect(1'b0, 4'hF, 1'h1);
    detect(1'b0, 4'h1, 1'h0);
    detect(1'b0, 4'h0, 1'h0);
    detect(1'b1, 4'hF, 1'h0);
    detect(1'b1, 4'h1, 1'h1);
    detect(1'b1, 4'h0, 1'h1);
    rd(8'h82, 8'h02);
    conclude();
  end
endmodule
